// File: obl_flash_ctl.sv
// Flash operation gate: block erase, write units and protection checks.
`timescale 1ns/1ps
module obl_flash_ctl (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Self-programming requests from software.
    input wire logic self_valid,
    input wire obl_pkg::obl_op_t self_op,
    input wire logic [obl_pkg::ADDR_W-1:0] self_addr,
    input wire logic [7:0] self_data,
    input wire logic [15:0] protect,
    // External programmer requests.
    input wire logic pgm_mode,
    input wire logic pgm_valid,
    input wire obl_pkg::obl_op_t pgm_op,
    input wire logic [obl_pkg::BLK_W-1:0] pgm_block,
    input wire logic [2:0] security,
    output logic pgm_ready,
    output logic pgm_refused,
    // Flash array operation port.
    output logic fl_op_valid,
    input wire logic fl_op_ready,
    output obl_pkg::obl_op_t fl_op_kind,
    output logic fl_op_block,
    output logic [obl_pkg::ADDR_W-1:0] fl_op_addr,
    output logic [7:0] fl_op_wdata,
    // Status.
    output logic busy,
    output logic self_refused
);

    logic busy_q;
    logic self_bad;
    logic pgm_bad;
    logic [obl_pkg::BLK_W-1:0] self_blk;

    // A self-programming chip erase is refused as well as an operation on a protected block.
    assign self_blk = self_addr[obl_pkg::BLK_LSB +: obl_pkg::BLK_W];
    assign self_bad = (self_op == obl_pkg::OP_CHIP_ERASE) || protect[self_blk];
    always_comb begin
        case (pgm_op)
            obl_pkg::OP_BLK_ERASE: pgm_bad = security[obl_pkg::SEC_BLK_ERASE];
            obl_pkg::OP_WRITE: pgm_bad = security[obl_pkg::SEC_BLK_WRITE];
            obl_pkg::OP_CHIP_ERASE: pgm_bad = security[obl_pkg::SEC_CHIP_ERASE];
            default: pgm_bad = 1'b1;
        endcase
    end
    assign pgm_ready = pgm_mode && !busy_q;
    assign busy = busy_q;

    // One operation in flight; it stands until the array takes it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q <= 1'b0;
            fl_op_kind <= obl_pkg::OP_NONE;
            fl_op_block <= 1'b0;
            fl_op_addr <= '0;
            fl_op_wdata <= 8'h00;
            pgm_refused <= 1'b0;
            self_refused <= 1'b0;
        end else begin
            pgm_refused <= 1'b0;
            self_refused <= 1'b0;
            if (busy_q) begin
                if (fl_op_ready) begin
                    busy_q <= 1'b0;
                end
            end else if (pgm_mode) begin
                if (pgm_valid && pgm_bad) begin
                    pgm_refused <= 1'b1;
                end else if (pgm_valid) begin
                    busy_q <= 1'b1;
                    fl_op_kind <= pgm_op;
                    fl_op_block <= 1'b1;
                    fl_op_addr <= {pgm_block, 8'h00};
                    fl_op_wdata <= 8'h00;
                end
            end else if (self_valid) begin
                if (self_bad) begin
                    self_refused <= 1'b1;
                end else begin
                    busy_q <= 1'b1;
                    fl_op_kind <= self_op;
                    fl_op_block <= 1'b0;
                    // Erase always targets the whole block holding the address.
                    fl_op_addr <= (self_op == obl_pkg::OP_BLK_ERASE) ?
                                  {self_blk, 8'h00} : self_addr;
                    fl_op_wdata <= self_data;
                end
            end
        end
    end
    assign fl_op_valid = busy_q;

endmodule : obl_flash_ctl

// File: obl_flash_model.sv
// Flash model that serves the configuration byte and array operations.
`timescale 1ns/1ps
module obl_flash_model (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Stored byte and fetch port.
    input wire logic [7:0] cfg_word,
    input wire logic cfg_rd_req,
    input wire logic [11:0] cfg_rd_addr,
    output logic cfg_rd_valid,
    output logic [7:0] cfg_rd_data,
    // Array operation port.
    input wire logic fl_op_valid,
    output logic fl_op_ready
);
    logic [1:0] wait_q;
    logic hit;
    assign hit = cfg_rd_req && wait_q == 2'h3 && cfg_rd_addr == obl_pkg::CFG_FLASH_ADDR;
    // Answers slowly; off the answer cycle the data shows the inverse, so stale bytes fail.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wait_q <= 2'h0;
            cfg_rd_valid <= 1'b0;
            fl_op_ready <= 1'b0;
        end else begin
            wait_q <= wait_q + 2'h1;
            cfg_rd_valid <= hit && !cfg_rd_valid;
            fl_op_ready <= fl_op_valid && wait_q[0] && !fl_op_ready;
        end
        cfg_rd_data <= hit ? cfg_word : ~cfg_word;
    end
endmodule : obl_flash_model

// File: obl_pkg.sv
// Shared constants and types for the boot configuration loader.
package obl_pkg;

    // Flash location of the configuration byte and flash organisation.
    localparam logic [11:0] CFG_FLASH_ADDR = 12'h080;
    localparam int FLASH_KB = 4;
    localparam int BLOCK_BYTES = 256;
    localparam int FLASH_BLOCKS = FLASH_KB * 1024 / BLOCK_BYTES;
    localparam int BLK_W = 4;
    localparam int ADDR_W = 12;
    localparam int BLK_LSB = 8;

    // Field positions inside the configuration byte.
    localparam int CFG_FIXED_MSB = 7;
    localparam int CFG_FIXED_LSB = 5;
    localparam int CFG_PULLUP_BIT = 4;
    localparam int CFG_ROLE_BIT = 3;
    localparam int CFG_CLK_HI_BIT = 2;
    localparam int CFG_CLK_LO_BIT = 1;
    localparam int CFG_LOCK_BIT = 0;
    localparam logic [7:0] CFG_RESET = 8'hFF;

    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [11:0] OFS_BOOT_CONFIG = 12'h080;
    localparam logic [11:0] OFS_STATUS = 12'h000;
    localparam logic [11:0] OFS_SLOW_OSC = 12'h004;
    localparam logic [11:0] OFS_WDT_CLK = 12'h008;
    localparam logic [11:0] OFS_PORT3_PU = 12'h00C;
    localparam logic [11:0] OFS_FL_CMD = 12'h010;
    localparam logic [11:0] OFS_FL_ADDR = 12'h014;
    localparam logic [11:0] OFS_FL_DATA = 12'h018;
    localparam logic [11:0] OFS_PROTECT = 12'h01C;
    localparam logic [11:0] OFS_SECURITY = 12'h020;

    // Bit positions inside the software registers, and AXI response codes.
    localparam int PU_RST_BIT = 4;
    localparam int SEC_CHIP_ERASE = 0;
    localparam int SEC_BLK_ERASE = 1;
    localparam int SEC_BLK_WRITE = 2;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    // Loader sequence and flash operation kinds.
    typedef enum logic [1:0] {ST_FETCH, ST_HOLD, ST_RUN} obl_state_t;
    typedef enum logic [1:0] {
        OP_NONE, OP_BLK_ERASE, OP_WRITE, OP_CHIP_ERASE
    } obl_op_t;

endpackage : obl_pkg

// File: obl_top.sv
// Boot configuration loader with AXI4-Lite registers and flash gate.
`timescale 1ns/1ps
module obl_top (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels.
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Configuration fetch read port.
    output logic cfg_rd_req,
    output logic [11:0] cfg_rd_addr,
    input wire logic cfg_rd_valid,
    input wire logic [7:0] cfg_rd_data,
    // Reset pin and core reset.
    input wire logic rst_pin_in,
    output logic rst_pin_pullup_en,
    output logic rst_shared_input_port,
    output logic core_rst_n,
    // Clock source and shared clock pin.
    output logic ext_clock_in_sel,
    output logic clk_shared_io_en,
    output logic cfg_clk_forbidden,
    // Low-speed oscillator, watchdog and timer clocks.
    input wire logic cpu_halt,
    input wire logic cpu_stop,
    output logic slow_osc_run,
    output logic watchdog_clk_en,
    output logic watchdog_clk_slow,
    output logic timer_clk_en,
    // External programmer.
    input wire logic pgm_mode,
    input wire logic pgm_valid,
    input wire obl_pkg::obl_op_t pgm_op,
    input wire logic [obl_pkg::BLK_W-1:0] pgm_block,
    output logic pgm_ready,
    output logic pgm_refused,
    // Flash array operation port.
    output logic fl_op_valid,
    input wire logic fl_op_ready,
    output obl_pkg::obl_op_t fl_op_kind,
    output logic fl_op_block,
    output logic [11:0] fl_op_addr,
    output logic [7:0] fl_op_wdata
);

    obl_pkg::obl_state_t state_q;
    logic [7:0] cfg_q;
    logic cfg_valid_q;
    logic slow_osc_halt_req_q;
    logic watchdog_sel_slow_q;
    logic [7:0] port3_pullup_reg_q;
    logic [11:0] fl_addr_q;
    logic [7:0] fl_data_q;
    logic [15:0] protect_q;
    logic [2:0] security_q;
    logic refused_q;
    logic aw_full_q;
    logic w_full_q;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic self_valid;
    obl_pkg::obl_op_t self_op;
    logic fl_busy;
    logic self_refused;
    logic rst_pin_role_sel;
    logic rst_pin_pullup_sel;
    logic slow_osc_lock;

    // Word-aligned register decode shared by both channels.
    function automatic logic is_reg(input logic [11:0] a, input logic [11:0] ofs);
        is_reg = (a[11:2] == ofs[11:2]);
    endfunction : is_reg

    // Fetch sequence; the pin is checked only once the byte is in hand.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= obl_pkg::ST_FETCH;
        end else begin
            case (state_q)
                obl_pkg::ST_FETCH: begin
                    if (cfg_rd_valid) begin
                        state_q <= rst_pin_in ? obl_pkg::ST_RUN : obl_pkg::ST_HOLD;
                    end
                end
                obl_pkg::ST_HOLD: begin
                    if (rst_pin_in) begin
                        state_q <= obl_pkg::ST_RUN;
                    end
                end
                obl_pkg::ST_RUN: state_q <= obl_pkg::ST_RUN;
                default: state_q <= obl_pkg::ST_FETCH;
            endcase
        end
    end
    assign cfg_rd_req = (state_q == obl_pkg::ST_FETCH);
    assign cfg_rd_addr = obl_pkg::CFG_FLASH_ADDR;

    // Configuration latch: loaded once per reset, no bus write reaches it.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= obl_pkg::CFG_RESET;
            cfg_valid_q <= 1'b0;
        end else if (state_q == obl_pkg::ST_FETCH && cfg_rd_valid) begin
            cfg_q <= cfg_rd_data;
            cfg_valid_q <= 1'b1;
        end
    end

    // Decoded reset pin settings.
    assign rst_pin_role_sel = cfg_q[obl_pkg::CFG_ROLE_BIT];
    assign rst_pin_pullup_sel = cfg_q[obl_pkg::CFG_PULLUP_BIT];
    assign rst_pin_pullup_en = rst_pin_role_sel ? rst_pin_pullup_sel :
                               port3_pullup_reg_q[obl_pkg::PU_RST_BIT];
    assign rst_shared_input_port = rst_pin_role_sel ? 1'b0 : rst_pin_in;
    // As a reset pin a low level holds the core in reset; as a port it does so only while the loader waits in ST_HOLD.
    assign core_rst_n = (state_q == obl_pkg::ST_RUN) &&
                        (rst_pin_in || !rst_pin_role_sel);

    // Clock source; the forbidden code falls back to the internal oscillator.
    assign ext_clock_in_sel = !cfg_q[obl_pkg::CFG_CLK_HI_BIT] &&
                              cfg_q[obl_pkg::CFG_CLK_LO_BIT];
    assign cfg_clk_forbidden = cfg_valid_q && !cfg_q[obl_pkg::CFG_CLK_HI_BIT] &&
                               !cfg_q[obl_pkg::CFG_CLK_LO_BIT];
    assign clk_shared_io_en = !ext_clock_in_sel;

    // Slow oscillator and the clocks that depend on it.
    assign slow_osc_lock = cfg_q[obl_pkg::CFG_LOCK_BIT];
    assign slow_osc_run = slow_osc_lock || !slow_osc_halt_req_q;
    assign watchdog_clk_slow = slow_osc_lock || watchdog_sel_slow_q;
    assign watchdog_clk_en = slow_osc_lock ||
                             (slow_osc_run && watchdog_sel_slow_q &&
                              !cpu_halt && !cpu_stop);
    assign timer_clk_en = slow_osc_run;

    // AXI write: address and data are taken independently, answer after both.
    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= obl_pkg::AXI_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_full_q) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_full_q) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Status up to security is one unbroken run of words, status included.
                s_axi_bresp <= (aw_addr_q[11:2] <= obl_pkg::OFS_SECURITY[11:2]) ?
                               obl_pkg::AXI_OKAY : obl_pkg::AXI_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Software registers; the configuration byte itself is read-only.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            slow_osc_halt_req_q <= 1'b0;
            watchdog_sel_slow_q <= 1'b1;
            port3_pullup_reg_q <= 8'h00;
            fl_addr_q <= 12'h000;
            fl_data_q <= 8'h00;
            protect_q <= 16'h0000;
            security_q <= 3'h0;
        end else if (wr_fire && w_strb_q[0]) begin
            if (is_reg(aw_addr_q, obl_pkg::OFS_SLOW_OSC)) begin
                slow_osc_halt_req_q <= w_data_q[0];
            end
            if (is_reg(aw_addr_q, obl_pkg::OFS_WDT_CLK)) begin
                watchdog_sel_slow_q <= w_data_q[0];
            end
            if (is_reg(aw_addr_q, obl_pkg::OFS_PORT3_PU)) begin
                port3_pullup_reg_q <= w_data_q[7:0];
            end
            if (is_reg(aw_addr_q, obl_pkg::OFS_FL_DATA)) begin
                fl_data_q <= w_data_q[7:0];
            end
            if (is_reg(aw_addr_q, obl_pkg::OFS_FL_ADDR) && w_strb_q[1]) begin
                fl_addr_q <= w_data_q[11:0];
            end
            if (is_reg(aw_addr_q, obl_pkg::OFS_PROTECT) && w_strb_q[1]) begin
                protect_q <= w_data_q[15:0];
            end
            // Security bits only ever turn on until the next reset.
            if (is_reg(aw_addr_q, obl_pkg::OFS_SECURITY)) begin
                security_q <= security_q | w_data_q[2:0];
            end
        end
    end

    // A command register write launches one self-programming operation.
    assign self_valid = wr_fire && w_strb_q[0] && is_reg(aw_addr_q, obl_pkg::OFS_FL_CMD);
    assign self_op = obl_pkg::obl_op_t'(w_data_q[1:0]);

    // Sticky refusal flag; a new refusal wins over the clearing write.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            refused_q <= 1'b0;
        end else if (self_refused) begin
            refused_q <= 1'b1;
        end else if (wr_fire && w_strb_q[0] && is_reg(aw_addr_q, obl_pkg::OFS_STATUS) &&
                     w_data_q[1]) begin
            refused_q <= 1'b0;
        end
    end

    // AXI read: one cycle from address acceptance to data.
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= obl_pkg::AXI_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= obl_pkg::AXI_OKAY;
            if (is_reg(s_axi_araddr, obl_pkg::OFS_BOOT_CONFIG)) begin
                s_axi_rdata <= {24'h000000, cfg_q};
            end else if (is_reg(s_axi_araddr, obl_pkg::OFS_STATUS)) begin
                s_axi_rdata <= {27'h0, cfg_clk_forbidden, slow_osc_run,
                                cfg_valid_q, refused_q, fl_busy};
            end else if (is_reg(s_axi_araddr, obl_pkg::OFS_SLOW_OSC)) begin
                s_axi_rdata <= {31'h0, slow_osc_halt_req_q};
            end else if (is_reg(s_axi_araddr, obl_pkg::OFS_WDT_CLK)) begin
                s_axi_rdata <= {31'h0, watchdog_sel_slow_q};
            end else if (is_reg(s_axi_araddr, obl_pkg::OFS_PORT3_PU)) begin
                s_axi_rdata <= {24'h000000, port3_pullup_reg_q};
            end else if (is_reg(s_axi_araddr, obl_pkg::OFS_FL_ADDR)) begin
                s_axi_rdata <= {20'h00000, fl_addr_q};
            end else if (is_reg(s_axi_araddr, obl_pkg::OFS_FL_DATA)) begin
                s_axi_rdata <= {24'h000000, fl_data_q};
            end else if (is_reg(s_axi_araddr, obl_pkg::OFS_PROTECT)) begin
                s_axi_rdata <= {16'h0000, protect_q};
            end else if (is_reg(s_axi_araddr, obl_pkg::OFS_SECURITY)) begin
                s_axi_rdata <= {29'h0, security_q};
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= is_reg(s_axi_araddr, obl_pkg::OFS_FL_CMD) ?
                               obl_pkg::AXI_OKAY : obl_pkg::AXI_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Flash gate for self-programming and programmer traffic.
    obl_flash_ctl u_flash (
        .aclk(aclk),
        .aresetn(aresetn),
        .self_valid(self_valid),
        .self_op(self_op),
        .self_addr(fl_addr_q),
        .self_data(fl_data_q),
        .protect(protect_q),
        .pgm_mode(pgm_mode),
        .pgm_valid(pgm_valid),
        .pgm_op(pgm_op),
        .pgm_block(pgm_block),
        .security(security_q),
        .pgm_ready(pgm_ready),
        .pgm_refused(pgm_refused),
        .fl_op_valid(fl_op_valid),
        .fl_op_ready(fl_op_ready),
        .fl_op_kind(fl_op_kind),
        .fl_op_block(fl_op_block),
        .fl_op_addr(fl_op_addr),
        .fl_op_wdata(fl_op_wdata),
        .busy(fl_busy),
        .self_refused(self_refused)
    );

    // Checks on the loader, clock gating, erase alignment and write response.
    property p_fetch_first;
        @(posedge aclk) disable iff (!aresetn) !cfg_valid_q |-> !core_rst_n;
    endproperty
    a_fetch_first: assert property (p_fetch_first) else $error("core ran before fetch");
    property p_pin_hold;
        @(posedge aclk) disable iff (!aresetn)
        (state_q == obl_pkg::ST_FETCH && cfg_rd_valid && !rst_pin_in) |=> !core_rst_n;
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("reset released with pin low");
    property p_latch_stable;
        @(posedge aclk) disable iff (!aresetn) cfg_valid_q |=> $stable(cfg_q);
    endproperty
    a_latch_stable: assert property (p_latch_stable) else $error("config latch changed");
    property p_pullup;
        @(posedge aclk) disable iff (!aresetn)
        rst_pin_pullup_en == (cfg_q[obl_pkg::CFG_ROLE_BIT] ? cfg_q[obl_pkg::CFG_PULLUP_BIT] :
                              port3_pullup_reg_q[obl_pkg::PU_RST_BIT]);
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up source wrong");
    property p_clk_pin;
        @(posedge aclk) disable iff (!aresetn)
        cfg_q[obl_pkg::CFG_CLK_HI_BIT] |-> (clk_shared_io_en && !ext_clock_in_sel);
    endproperty
    a_clk_pin: assert property (p_clk_pin) else $error("internal clock lost shared pin");
    property p_lock;
        @(posedge aclk) disable iff (!aresetn)
        slow_osc_lock |-> (slow_osc_run && watchdog_clk_slow && watchdog_clk_en);
    endproperty
    a_lock: assert property (p_lock) else $error("locked oscillator not forced");
    property p_wdt_gate;
        @(posedge aclk) disable iff (!aresetn)
        (!slow_osc_lock && (cpu_halt || cpu_stop || !watchdog_sel_slow_q)) |-> !watchdog_clk_en;
    endproperty
    a_wdt_gate: assert property (p_wdt_gate) else $error("watchdog clock not gated");
    property p_timer;
        @(posedge aclk) disable iff (!aresetn)
        (cpu_stop && !slow_osc_halt_req_q) |-> timer_clk_en;
    endproperty
    a_timer: assert property (p_timer) else $error("timer clock lost in stop");
    property p_erase_align;
        @(posedge aclk) disable iff (!aresetn)
        (fl_op_valid && fl_op_kind == obl_pkg::OP_BLK_ERASE) |-> (fl_op_addr[7:0] == 8'h00);
    endproperty
    a_erase_align: assert property (p_erase_align) else $error("erase not block aligned");
    property p_write_resp;
        @(posedge aclk) disable iff (!aresetn) wr_fire |=> s_axi_bvalid;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("write response missing");

endmodule : obl_top

// File: obl_top_tb_top.sv
// Testbench for the boot configuration loader.
`timescale 1ns/1ps
module obl_top_tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, rst_pin_in = 1'b1, cpu_halt = 1'b0, cpu_stop = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pgm_mode = 1'b0, pgm_valid = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, cfg_rd_addr, fl_op_addr;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
    logic [3:0] s_axi_wstrb = 4'hF, pgm_block = 4'h3;
    obl_pkg::obl_op_t pgm_op = obl_pkg::OP_BLK_ERASE, fl_op_kind;
    logic [7:0] cfg_word = 8'hEB, cfg_rd_data, fl_op_wdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
    logic [22:0] op_seen;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cfg_rd_req;
    logic cfg_rd_valid, rst_pin_pullup_en, rst_shared_input_port, core_rst_n, ext_clock_in_sel;
    logic clk_shared_io_en, cfg_clk_forbidden, slow_osc_run, watchdog_clk_en, watchdog_clk_slow;
    logic timer_clk_en, pgm_ready, pgm_refused, fl_op_valid, fl_op_ready, fl_op_block;
    int errors = 0, check_count = 0;
    obl_top obl_top_i (.*);
    obl_flash_model obl_flash_model_i (.*);
    // Free-running 100 MHz clock.
    always #5 aclk = ~aclk;
    // Array operation as it stands at the edge on which the flash takes it.
    always @(posedge aclk)
        if (fl_op_valid && fl_op_ready) op_seen <= {fl_op_kind, fl_op_block, fl_op_addr, fl_op_wdata};
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) {s_axi_bready, wr_resp} <= {1'b0, s_axi_bresp};
        end while (s_axi_awvalid | s_axi_wvalid | s_axi_bready);
        #1;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) {s_axi_rready, rd_data, rd_resp} <= {1'b0, s_axi_rdata, s_axi_rresp};
        end while (s_axi_arvalid | s_axi_rready);
        #1;
    endtask : rd
    task automatic boot(input logic [7:0] w);
        cfg_word <= w;
        aresetn <= 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
    endtask : boot
    task automatic wait_run;
        while (core_rst_n !== 1'b1) @(posedge aclk);
        #1;
    endtask : wait_run
    // Main sequence: one boot per configuration byte.
    initial begin
        boot(8'hEB);
        wait_run;
        chk({cfg_clk_forbidden, rst_pin_pullup_en, ext_clock_in_sel, clk_shared_io_en}, 4'h2);
        wr(12'h004, 32'h1);
        wr(12'h008, 32'h0);
        chk({slow_osc_run, watchdog_clk_slow, watchdog_clk_en}, 3'h7);
        chk(wr_resp, obl_pkg::AXI_OKAY);
        wr(12'h080, 32'h0);
        chk(wr_resp, obl_pkg::AXI_SLVERR);
        rd(12'h080);
        chk(rd_data, 32'hEB);
        rd(12'h0FC);
        chk(rd_resp, obl_pkg::AXI_SLVERR);
        rst_pin_in <= 1'b0;
        @(posedge aclk) #1 chk(core_rst_n, 1'b0);
        $display("test reset role done");
        boot(8'hF4);
        repeat (20) @(posedge aclk);
        chk(core_rst_n, 1'b0);
        rst_pin_in <= 1'b1;
        wait_run;
        chk({rst_pin_pullup_en, rst_shared_input_port, clk_shared_io_en}, 3'h3);
        rst_pin_in <= 1'b0;
        @(posedge aclk) #1 chk({core_rst_n, rst_shared_input_port}, 2'h2);
        wr(12'h00C, 32'h10);
        chk(rst_pin_pullup_en, 1'b1);
        cpu_stop <= 1'b1;
        @(posedge aclk) #1 chk({watchdog_clk_en, timer_clk_en}, 2'h1);
        wr(12'h004, 32'h1);
        chk({slow_osc_run, timer_clk_en}, 2'h0);
        $display("test port role done");
        wr(12'h01C, 32'h8);
        wr(12'h014, 32'h345);
        wr(12'h010, 32'h1);
        rd(12'h000);
        chk(rd_data, 32'h6);
        wr(12'h000, 32'h2);
        chk(wr_resp, obl_pkg::AXI_OKAY);
        wr(12'h01C, 32'h0);
        wr(12'h018, 32'h5A);
        wr(12'h010, 32'h2);
        rd(12'h000);
        chk(rd_data, 32'h4);
        chk(op_seen, {obl_pkg::OP_WRITE, 1'b0, 12'h345, 8'h5A});
        wr(12'h010, 32'h1);
        rd(12'h000);
        chk(op_seen, {obl_pkg::OP_BLK_ERASE, 1'b0, 12'h300, 8'h5A});
        $display("test self programming done");
        {pgm_mode, pgm_valid} <= 2'h3;
        do @(posedge aclk); while (pgm_ready !== 1'b1);
        pgm_valid <= 1'b0;
        while (fl_op_valid !== 1'b1) @(posedge aclk);
        chk({fl_op_block, fl_op_addr}, {1'b1, 12'h300});
        wr(12'h020, 32'h2);
        pgm_valid <= 1'b1;
        do @(posedge aclk); while (pgm_ready !== 1'b1);
        pgm_valid <= 1'b0;
        #1 chk({pgm_refused, fl_op_valid}, 2'h2);
        $display("test programmer erase done");
        give_verdict;
    end
    // Cuts a hang short well past the expected run length.
    initial begin
        #200000;
        errors++;
        give_verdict;
    end
endmodule : obl_top_tb_top
